// *** aer_pkg.sv ***
/*
 Package for the error-reporting register bank: offsets, field positions,
 reset values and the carrier structs.
 Assumes a 32-bit AXI4-Lite register bus and single clock domain.
*/
package aer_pkg;
   localparam logic [11:0] AER_SEV_OFS = 12'h10C;
   localparam logic [11:0] AER_CES_OFS = 12'h110;
   localparam logic [11:0] AER_UEM_OFS = 12'h108;
   localparam logic [11:0] AER_CEM_OFS = 12'h114;
   // Writable severity bits and their reset value
   localparam logic [31:0] AER_SEV_RW_MASK = 32'h001F3031;
   localparam logic [31:0] AER_SEV_RST = 32'h00062030;
   // Severity bits that may steer a report; bit 0 is writable but inert
   localparam logic [31:0] AER_SEV_LIVE_MASK = 32'h001F3030;
   localparam logic [31:0] AER_UEM_RW_MASK = 32'h001F3031;
   localparam logic [31:0] AER_UEM_RST = 32'h00000000;
   localparam logic [31:0] AER_CES_MASK = 32'h000031C1;
   localparam logic [31:0] AER_CEM_RST = 32'h00002000;
   localparam logic [1:0] AER_RESP_OKAY = 2'h0;
   localparam logic [1:0] AER_RESP_SLVERR = 2'h2;
   localparam int AER_BIT_RCV = 0;
   localparam int AER_BIT_BADTP = 6;
   localparam int AER_BIT_BADLP = 7;
   localparam int AER_BIT_ROLL = 8;
   localparam int AER_BIT_RTO = 12;
   localparam int AER_BIT_ADV = 13;

   typedef struct packed {
      logic [31:0] sev;
      logic [31:0] uem;
      logic [31:0] ces;
      logic [31:0] cem;
      logic aw_got;
      logic [11:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic fatal;
      logic nonfatal;
      logic correctable;
   } aer_state_t;

   typedef struct packed {
      logic [31:0] uncorr;
      logic [31:0] corr;
   } aer_events_t;

   typedef struct packed {
      logic fatal;
      logic nonfatal;
      logic correctable;
   } aer_report_t;
endpackage

// *** aer_rc_model.sv ***
/*
 Root complex stand-in: counts the error reports of each class.
 Assumes report pulses last one cycle and are synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module aer_rc_model
   import aer_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Reports from the port
   input wire aer_pkg::aer_report_t report,
   // Running totals
   output logic [7:0] n_fatal,
   output logic [7:0] n_nonfatal,
   output logic [7:0] n_corr
);
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         n_fatal <= 8'h00;
         n_nonfatal <= 8'h00;
         n_corr <= 8'h00;
      end
      else
      begin
         n_fatal <= n_fatal + {7'h00, report.fatal};
         n_nonfatal <= n_nonfatal + {7'h00, report.nonfatal};
         n_corr <= n_corr + {7'h00, report.correctable};
      end
   end
endmodule
`default_nettype wire

// *** aer_regs.sv ***
/*
 Error severity and correctable status register bank for one switch port,
 with an AXI4-Lite slave. Assumes event inputs are one-cycle pulses from
 logic on clk, one bit per error position of the status layout.
*/
// The AXI4-Lite slave port was chosen for this implementation.
// What this block does
// [R1] Unmasked uncorrectable event at a bit of AER_SEV_LIVE_MASK reports fatal if severity one, else nonfatal.
// [R2] Severity applies only to unmasked events; masked ones get no report.
// [R3] Severity bit 4, link protocol, read-write sticky, resets to one.
// [R4] Severity bit 5, surprise down, read-write sticky, resets to one.
// [R5] Severity bit 12, poisoned packet, read-write sticky, resets to zero.
// [R6] Severity bit 13, flow control protocol, read-write, resets to one.
// [R7] Severity bit 16, unexpected completion, read-write, resets to zero.
// [R8] Severity bit 17, receiver overflow, read-write sticky, resets to one.
// [R9] Severity bit 18, malformed packet, read-write sticky, resets to one.
// [R10] Severity bit 19, end-to-end CRC, read-write sticky, resets to zero.
// [R11] Severity bit 20, unsupported request, read-write, resets to zero.
// [R12] Severity bit 14, completion timeout, reads zero always.
// [R13] Severity bit 15, completer abort, reads zero always.
// [R14] Severity bit 0 is unused read-write sticky, resets zero, no effect.
// [R15] Status bit 0 sets on receiver error; sticky, write one clears.
// [R16] Status bit 6 sets on bad transaction packet; write one clears.
// [R17] Status bit 7 sets on bad link packet; write one clears.
// [R18] Status bit 8 sets on replay number rollover; write one clears.
// [R19] Status bit 12 sets on replay timer expiry; write one clears.
// [R20] Status bit 13 sets on advisory nonfatal error; write one clears.
// [R21] Masked uncorrectable event is neither logged nor reported.
// [R22] Masked correctable event not reported, status still set.
// [R23] Reserved bits read zero, ignore writes; writing zero keeps status.
`timescale 1ns/10ps
`default_nettype none
module aer_regs
   import aer_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // AXI4-Lite write address and data
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [11:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Error events and reports toward the root complex
   input wire aer_pkg::aer_events_t events,
   output aer_pkg::aer_report_t report
);
   import aer_pkg::*;

   aer_state_t q;
   aer_state_t d;

   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   function automatic logic addr_ok(input logic [11:0] a);
      addr_ok = (a == AER_SEV_OFS) || (a == AER_CES_OFS) ||
         (a == AER_UEM_OFS) || (a == AER_CEM_OFS);
   endfunction

   logic do_write;
   logic [31:0] wm;
   logic [31:0] unc_live;

   assign s_axi_awready = !q.aw_got && !q.bvalid;
   assign s_axi_wready = !q.w_got && !q.bvalid;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign report.fatal = q.fatal;
   assign report.nonfatal = q.nonfatal;
   assign report.correctable = q.correctable;

   always_comb
   begin
      d = q;
      if (s_axi_awvalid && s_axi_awready)
      begin
         d.aw_got = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         d.w_got = 1'b1;
         d.w_data = s_axi_wdata;
         d.w_strb = s_axi_wstrb;
      end
      do_write = d.aw_got && d.w_got && !q.bvalid;
      wm = strb_mask(d.w_strb);
      // Only writable positions are touched; reserved stay zero
      if (do_write && d.aw_addr == AER_SEV_OFS)
         d.sev = (q.sev & ~(wm & AER_SEV_RW_MASK)) |
            (d.w_data & wm & AER_SEV_RW_MASK); // R3 R4 R5 R6 R7 R8 R9 R10 R11 R12 R13 R14 R23
      if (do_write && d.aw_addr == AER_UEM_OFS)
         d.uem = (q.uem & ~(wm & AER_UEM_RW_MASK)) |
            (d.w_data & wm & AER_UEM_RW_MASK);
      if (do_write && d.aw_addr == AER_CEM_OFS)
         d.cem = (q.cem & ~(wm & AER_CES_MASK)) |
            (d.w_data & wm & AER_CES_MASK);
      // Clear first, then set: an event in the clear cycle survives
      if (do_write && d.aw_addr == AER_CES_OFS)
         d.ces = q.ces & ~(d.w_data & wm); // R23
      d.ces = (d.ces | events.corr) & AER_CES_MASK; // R15 R16 R17 R18 R19 R20
      if (do_write)
      begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = addr_ok(d.aw_addr) ? AER_RESP_OKAY : AER_RESP_SLVERR;
      end
      else if (q.bvalid && s_axi_bready)
         d.bvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         d.rvalid = 1'b1;
         d.rresp = addr_ok(s_axi_araddr) ? AER_RESP_OKAY : AER_RESP_SLVERR;
         case (s_axi_araddr)
            AER_SEV_OFS: d.rdata = q.sev;
            AER_CES_OFS: d.rdata = q.ces;
            AER_UEM_OFS: d.rdata = q.uem;
            AER_CEM_OFS: d.rdata = q.cem;
            default: d.rdata = 32'h00000000;
         endcase
      end
      else if (q.rvalid && s_axi_rready)
         d.rvalid = 1'b0;
      // Bit 0 and severity 14/15 never steer a report
      unc_live = events.uncorr & AER_SEV_LIVE_MASK & ~q.uem; // R2 R21 R14
      d.fatal = |(unc_live & q.sev); // R1
      d.nonfatal = |(unc_live & ~q.sev); // R1
      d.correctable = |(events.corr & AER_CES_MASK & ~q.cem); // R22
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         q <= '0;
         q.sev <= AER_SEV_RST; // R3 R4 R5 R6 R7 R8 R9 R10 R11 R14
         q.uem <= AER_UEM_RST;
         q.cem <= AER_CEM_RST;
      end
      else
         q <= d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   // Report steering

   a_fatal_report: assert property ( // R1
      @(posedge clk) disable iff (rst)
      (|(events.uncorr & ~q.uem & q.sev & AER_SEV_LIVE_MASK)) |=> report.fatal)
      else $error("unmasked high-severity event not fatal");

   a_nonfatal_report: assert property ( // R1
      @(posedge clk) disable iff (rst)
      (|(events.uncorr & ~q.uem & ~q.sev & AER_SEV_LIVE_MASK)) |=>
      report.nonfatal)
      else $error("unmasked low-severity event not nonfatal");

   a_fatal_cause: assert property ( // R1
      @(posedge clk) disable iff (rst)
      !(|(events.uncorr & ~q.uem & q.sev & AER_SEV_LIVE_MASK)) |=>
      !report.fatal)
      else $error("fatal report without a fatal event");

   a_nonfatal_cause: assert property ( // R1
      @(posedge clk) disable iff (rst)
      !(|(events.uncorr & ~q.uem & ~q.sev & AER_SEV_LIVE_MASK)) |=>
      !report.nonfatal)
      else $error("nonfatal report without a nonfatal event");

   a_masked_silent: assert property ( // R2
      @(posedge clk) disable iff (rst)
      ((events.uncorr & ~q.uem) == 32'h00000000) |=>
      !report.fatal && !report.nonfatal)
      else $error("masked event reported");

   a_unused_inert: assert property ( // R14
      @(posedge clk) disable iff (rst)
      ((events.uncorr & ~q.uem & AER_SEV_LIVE_MASK) == 32'h00000000) |=>
      !report.fatal && !report.nonfatal)
      else $error("unused severity bit steered a report");

   a_corr_report: assert property ( // R22
      @(posedge clk) disable iff (rst)
      (|(events.corr & ~q.cem & AER_CES_MASK)) |=> report.correctable)
      else $error("unmasked correctable event not reported");

   a_corr_masked: assert property ( // R22
      @(posedge clk) disable iff (rst)
      ((events.corr & ~q.cem & AER_CES_MASK) == 32'h00000000) |=>
      !report.correctable)
      else $error("masked correctable reported");

   ////////////////////////////////////////////////////////////////////////
   // Severity and mask register contents

   a_sev_fixed_zero: assert property ( // R12
      @(posedge clk) disable iff (rst)
      (q.sev & ~AER_SEV_RW_MASK) == 32'h00000000)
      else $error("fixed severity bits not zero");

   a_sev_hw_zero: assert property ( // R13
      @(posedge clk) disable iff (rst)
      q.sev[15:14] == 2'h0)
      else $error("severity 14 or 15 set");

   a_sev_res_low: assert property ( // R23
      @(posedge clk) disable iff (rst)
      q.sev[3:1] == 3'h0)
      else $error("severity bits 3 to 1 set");

   a_sev_res_mid: assert property ( // R23
      @(posedge clk) disable iff (rst)
      q.sev[11:6] == 6'h00)
      else $error("severity bits 11 to 6 set");

   a_sev_res_high: assert property ( // R23
      @(posedge clk) disable iff (rst)
      q.sev[31:21] == 11'h000)
      else $error("severity bits 31 to 21 set");

   a_sev_sticky: assert property ( // R3
      @(posedge clk) disable iff (rst)
      !(do_write && d.aw_addr == AER_SEV_OFS) |=> q.sev == $past(q.sev))
      else $error("severity changed without a write");

   a_sev_lands: assert property ( // R5
      @(posedge clk) disable iff (rst)
      (do_write && d.aw_addr == AER_SEV_OFS && (&wm)) |=>
      q.sev == ($past(d.w_data) & AER_SEV_RW_MASK))
      else $error("severity write did not land");

   a_sev_read_zero: assert property ( // R12
      @(posedge clk) disable iff (rst)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == AER_SEV_OFS) |=>
      s_axi_rdata[15:14] == 2'h0)
      else $error("severity 14 or 15 read as one");

   a_uem_reserved: assert property ( // R23
      @(posedge clk) disable iff (rst)
      (q.uem & ~AER_UEM_RW_MASK) == 32'h00000000)
      else $error("reserved mask bit set");

   a_cem_reserved: assert property ( // R23
      @(posedge clk) disable iff (rst)
      (q.cem & ~AER_CES_MASK) == 32'h00000000)
      else $error("reserved correctable mask bit set");

   ////////////////////////////////////////////////////////////////////////
   // Correctable status

   a_rcv_sets: assert property ( // R15
      @(posedge clk) disable iff (rst)
      events.corr[AER_BIT_RCV] |=> q.ces[AER_BIT_RCV])
      else $error("receiver error not latched");

   a_badtp_sets: assert property ( // R16
      @(posedge clk) disable iff (rst)
      events.corr[AER_BIT_BADTP] |=> q.ces[AER_BIT_BADTP])
      else $error("bad packet not latched");

   a_status_sticky: assert property ( // R16
      @(posedge clk) disable iff (rst)
      (q.ces[AER_BIT_BADTP] && !(s_axi_wvalid || q.w_got)) |=>
      q.ces[AER_BIT_BADTP])
      else $error("bad packet status lost without write");

   a_link_sets: assert property ( // R17
      @(posedge clk) disable iff (rst)
      events.corr[AER_BIT_BADLP] |=> q.ces[AER_BIT_BADLP])
      else $error("bad link packet not latched");

   a_roll_sets: assert property ( // R18
      @(posedge clk) disable iff (rst)
      events.corr[AER_BIT_ROLL] |=> q.ces[AER_BIT_ROLL])
      else $error("rollover not latched");

   a_rto_sets: assert property ( // R19
      @(posedge clk) disable iff (rst)
      events.corr[AER_BIT_RTO] |=> q.ces[AER_BIT_RTO])
      else $error("replay timeout not latched");

   a_adv_sets: assert property ( // R20
      @(posedge clk) disable iff (rst)
      events.corr[AER_BIT_ADV] |=> q.ces[AER_BIT_ADV])
      else $error("advisory not latched");

   a_rcv_clears: assert property ( // R15
      @(posedge clk) disable iff (rst)
      (do_write && d.aw_addr == AER_CES_OFS && d.w_data[AER_BIT_RCV] &&
      wm[AER_BIT_RCV] && !events.corr[AER_BIT_RCV]) |=> !q.ces[AER_BIT_RCV])
      else $error("receiver error not cleared by one");

   a_zero_keeps: assert property ( // R23
      @(posedge clk) disable iff (rst)
      (do_write && d.aw_addr == AER_CES_OFS && q.ces[AER_BIT_RTO] &&
      !(d.w_data[AER_BIT_RTO] && wm[AER_BIT_RTO])) |=> q.ces[AER_BIT_RTO])
      else $error("status lost on a zero write");

   a_ces_reserved: assert property ( // R23
      @(posedge clk) disable iff (rst)
      (q.ces & ~AER_CES_MASK) == 32'h00000000)
      else $error("reserved status bit set");

   ////////////////////////////////////////////////////////////////////////
   // Register bus

   a_read_answer: assert property (
      @(posedge clk) disable iff (rst)
      (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
      else $error("read not answered next cycle");

   a_write_answer: assert property (
      @(posedge clk) disable iff (rst)
      do_write |=> s_axi_bvalid)
      else $error("write not answered next cycle");

   a_bvalid_holds: assert property (
      @(posedge clk) disable iff (rst)
      (s_axi_bvalid && !s_axi_bready) |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");

   a_rvalid_holds: assert property (
      @(posedge clk) disable iff (rst)
      (s_axi_rvalid && !s_axi_rready) |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");

   a_write_blocked: assert property (
      @(posedge clk) disable iff (rst)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");

   a_read_blocked: assert property (
      @(posedge clk) disable iff (rst)
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");

   a_bresp_unmapped: assert property ( // R23
      @(posedge clk) disable iff (rst)
      (do_write && !addr_ok(d.aw_addr)) |=> s_axi_bresp == AER_RESP_SLVERR)
      else $error("unmapped write not refused");

   a_rdata_unmapped: assert property ( // R23
      @(posedge clk) disable iff (rst)
      (s_axi_arvalid && s_axi_arready && !addr_ok(s_axi_araddr)) |=>
      s_axi_rdata == 32'h00000000)
      else $error("unmapped read returned data");

   ////////////////////////////////////////////////////////////////////////
   // Main scenarios reached

   c_fatal: cover property (@(posedge clk) disable iff (rst) report.fatal);
   c_nonfatal: cover property (@(posedge clk) disable iff (rst)
      report.nonfatal);
   c_corr: cover property (@(posedge clk) disable iff (rst)
      report.correctable);
   c_write: cover property (@(posedge clk) disable iff (rst)
      s_axi_bvalid && s_axi_bready);
   c_read: cover property (@(posedge clk) disable iff (rst)
      s_axi_rvalid && s_axi_rready);
endmodule
`default_nettype wire

// *** test_aer_regs.sv ***
/*
 Self-checking bench for the error register bank.
 Assumes the package offsets and the root complex stand-in.
*/
`timescale 1ns/10ps
`default_nettype none
module test_aer_regs;
   import aer_pkg::*;
   logic clk, rst, awv, wv, bre, arv, rre, awr, wrd, bv, arr, rv;
   logic [11:0] awa, ara;
   logic [31:0] wd, rd, v, ec;
   logic [3:0] ws;
   logic [1:0] br, rr, rs;
   aer_events_t ev;
   aer_report_t rep;
   logic [7:0] nf, nn, nc;
   int failures, samples_checked;
   int bits[6] = '{0, 6, 7, 8, 12, 13};
   aer_regs u_dut (.clk(clk), .rst(rst), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(ws),
      .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
      .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rd),
      .s_axi_rresp(rr), .events(ev), .report(rep));
   aer_rc_model u_rc (.clk(clk), .rst(rst), .report(rep),
      .n_fatal(nf), .n_nonfatal(nn), .n_corr(nc));
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] s, e);
      samples_checked++;
      if (s !== e)
      begin
         failures++;
         $display("wrong value %s exp %h seen %h", n, e, s);
      end
   endtask
   // Each channel released on its own handshake
   // Readies are read mid-cycle, where they are settled; next edge takes
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic ta, tw, ta_n, tw_n;
      ta = 1'b0;
      tw = 1'b0;
      awv <= 1'b1;
      wv <= 1'b1;
      awa <= a;
      wd <= d;
      while (!(ta && tw))
      begin
         @(negedge clk);
         ta_n = ta || awr;
         tw_n = tw || wrd;
         @(posedge clk);
         ta = ta_n;
         tw = tw_n;
         awv <= !ta;
         wv <= !tw;
      end
      bre <= 1'b1;
      do @(negedge clk); while (!bv);
      rs = br;
      @(posedge clk);
      bre <= 1'b0;
   endtask
   task automatic rdr(input logic [11:0] a);
      arv <= 1'b1;
      ara <= a;
      do @(negedge clk); while (!arr);
      @(posedge clk);
      arv <= 1'b0;
      rre <= 1'b1;
      do @(negedge clk); while (!rv);
      v = rd;
      rs = rr;
      @(posedge clk);
      rre <= 1'b0;
   endtask
   // Two spare edges let the report reach the counters
   task automatic pulse(input logic [31:0] u, c);
      ev <= {u, c};
      @(posedge clk);
      ev <= '0;
      repeat (2) @(posedge clk);
   endtask
   task automatic print_verdict;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial
   begin
      #100000;
      failures++;
      print_verdict();
   end
   initial
   begin
      {rst, awv, wv, bre, arv, rre} = 6'h20;
      {awa, ara, wd, ws, ev} = '0;
      ws = 4'hF;
      failures = 0;
      samples_checked = 0;
      ec = 32'h0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rdr(AER_SEV_OFS);
      chk("sev reset", v, 32'h00062030);
      rdr(AER_CES_OFS);
      chk("ces reset", v, 32'h0);
      wr(AER_SEV_OFS, 32'hFFFFFFFF);
      chk("sev bresp", {30'h0, rs}, {30'h0, AER_RESP_OKAY});
      rdr(AER_SEV_OFS);
      chk("sev ones", v, 32'h001F3031);
      wr(12'h200, 32'hFFFFFFFF);
      chk("unmapped bresp", {30'h0, rs}, {30'h0, AER_RESP_SLVERR});
      rdr(12'h200);
      chk("unmapped rresp", {30'h0, rs}, {30'h0, AER_RESP_SLVERR});
      $display("test severity done");
      foreach (bits[i])
      begin
         pulse(32'h0, 32'h1 << bits[i]);
         ec = ec + (bits[i] != 13);
         rdr(AER_CES_OFS);
         chk("ces set", v, 32'h1 << bits[i]);
         chk("corr count", {24'h0, nc}, ec);
         wr(AER_CES_OFS, 32'h1 << bits[i]);
         rdr(AER_CES_OFS);
         chk("ces clear", v, 32'h0);
      end
      pulse(32'h0, 32'hFFFFFFFF);
      wr(AER_CES_OFS, 32'h0);
      rdr(AER_CES_OFS);
      chk("ces zero wr", v, 32'h000031C1);
      chk("corr all", {24'h0, nc}, ec + 1);
      wr(AER_CES_OFS, 32'h1);
      rdr(AER_CES_OFS);
      chk("ces w1c one", v, 32'h000031C0);
      $display("test correctable done");
      wr(AER_SEV_OFS, 32'h00000010);
      pulse(32'h10, 32'h0);
      pulse(32'h1000, 32'h0);
      chk("fatal", {24'h0, nf}, 32'h1);
      chk("nonfatal", {24'h0, nn}, 32'h1);
      wr(AER_UEM_OFS, 32'h00001010);
      pulse(32'h1010, 32'h0);
      chk("masked fatal", {24'h0, nf}, 32'h1);
      chk("masked nonfatal", {24'h0, nn}, 32'h1);
      $display("test severity report done");
      print_verdict();
   end
endmodule
`default_nettype wire
